// ### core/sfl_device.sv
// serial frame controller: bit-stuffed framing, check sequence, byte strobes
// Notes on behaviour
// - fill select low flags, high ones
// - user raises pending when packet ready
// - user marks last byte with request
// - byte captured on edge with request
// - request is one link-cycle pulse
// - pending low at request pulses underrun
// - transmit changes on link clock rise
// - serial output changes only on rise
// - transmit advances only while enabled
// - receive advances only while enabled
// - serial input sampled each receive rise
// - width select picks 16 or 32 bits
// - user shows room for more bytes
// - reset clears every device register at once; user-end registers clear on the next mclk edge
// - bytes then status on output bus
// - one strobe pulse per delivered byte
// - first byte carries first marker
// - last check byte carries end marker
// - status byte carries status marker
// - receive changes on link clock rise
// - complemented check value is sent
// - zero inserted after five ones
// - zero after five ones is dropped
// - underrun aborts with eight ones
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sfl_device (
	input wire logic mclk,
	input wire logic rst_n,
	sfl_link_if.device lnk,
	input wire logic fillSelect,
	input wire logic checkWidthSelect,
	input wire logic rxLine,
	output logic txLine
);
	typedef struct packed {
		logic [2:0] txClkSync;
		logic [2:0] rxClkSync;
		logic [1:0] rxLineSync;
		sfl_pkg::sfl_tx_state_type txState;
		logic txAbort;
		logic [7:0] txShift;
		logic [2:0] txBitCnt;
		logic [3:0] txOnes;
		logic txStuff;
		logic txLastCap;
		logic [2:0] txFcsLeft;
		logic [31:0] txCrc;
		logic txLine;
		logic txLoad;
		logic txUnderrun;
		sfl_pkg::sfl_rx_state_type rxState;
		logic [7:0] rxWin;
		logic [3:0] rxOnes;
		logic [7:0] rxShift;
		logic [2:0] rxBitCnt;
		logic [31:0] rxCrc;
		logic [7:0] rxHold;
		logic rxHoldValid;
		logic [31:0] rxHoldCrc;
		logic [2:0] rxCount;
		logic rxFirstPend;
		logic rxStatPend;
		logic [7:0] rxStatByte;
		logic [7:0] rxByte;
		logic rxStb;
		logic rxFirst;
		logic rxEnd;
		logic rxStat;
	} sfl_dev_state_type;

	sfl_dev_state_type s_r;
	sfl_dev_state_type s_nxt;

	always_comb begin
		logic [7:0] cur;
		logic bitIn;
		logic [3:0] onesNew;
		logic [7:0] stat;
		logic [7:0] fillByte;
		logic txStep;
		logic rxStep;
		cur = 8'h00;
		bitIn = 1'b0;
		onesNew = 4'h0;
		stat = 8'h00;
		s_nxt = s_r;
		fillByte = fillSelect ? sfl_pkg::ONES_BYTE : sfl_pkg::FLAG_BYTE;
		s_nxt.txClkSync = {s_r.txClkSync[1:0], lnk.txSerialClock};
		s_nxt.rxClkSync = {s_r.rxClkSync[1:0], lnk.rxSerialClock};
		s_nxt.rxLineSync = {s_r.rxLineSync[0], rxLine};
		txStep = s_r.txClkSync[1] & ~s_r.txClkSync[2] & lnk.txEn;
		rxStep = s_r.rxClkSync[1] & ~s_r.rxClkSync[2] & lnk.rxEn;

		if (txStep) begin
			s_nxt.txLoad = 1'b0;
			s_nxt.txUnderrun = 1'b0;
			cur = s_r.txLoad ? lnk.txByte : s_r.txShift;
			if (s_r.txLoad) begin
				s_nxt.txLastCap = lnk.txLast;
				if (!lnk.txPending) begin
					s_nxt.txUnderrun = 1'b1;
					s_nxt.txAbort = 1'b1;
					s_nxt.txState = sfl_pkg::TX_FILL;
					cur = sfl_pkg::ONES_BYTE;
				end
			end
			if (s_r.txStuff && !s_nxt.txAbort) begin
				s_nxt.txLine = 1'b0;
				s_nxt.txStuff = 1'b0;
				s_nxt.txOnes = 4'h0;
				s_nxt.txShift = cur;
			end else begin
				bitIn = cur[0];
				s_nxt.txLine = bitIn;
				s_nxt.txStuff = 1'b0;
				s_nxt.txShift = {1'b0, cur[7:1]};
				s_nxt.txBitCnt = s_r.txBitCnt + 3'h1;
				if (s_nxt.txState == sfl_pkg::TX_DATA) begin
					s_nxt.txCrc = sfl_pkg::crcStep(s_r.txCrc, bitIn, checkWidthSelect);
				end
				if (s_nxt.txState == sfl_pkg::TX_DATA || s_nxt.txState == sfl_pkg::TX_FCS) begin
					s_nxt.txOnes = bitIn ? s_r.txOnes + 4'h1 : 4'h0;
					s_nxt.txStuff = (s_nxt.txOnes == sfl_pkg::STUFF_RUN);
				end
				if (s_r.txBitCnt == 3'h7) begin
					s_nxt.txAbort = 1'b0;
					case (s_nxt.txState)
						sfl_pkg::TX_FILL: begin
							s_nxt.txShift = lnk.txPending ? sfl_pkg::FLAG_BYTE : fillByte;
							s_nxt.txState = lnk.txPending ? sfl_pkg::TX_FLAG : sfl_pkg::TX_FILL;
						end
						sfl_pkg::TX_FLAG: begin
							if (lnk.txPending) begin
								s_nxt.txLoad = 1'b1;
								s_nxt.txState = sfl_pkg::TX_DATA;
								s_nxt.txOnes = 4'h0;
								s_nxt.txCrc = checkWidthSelect ? sfl_pkg::CRC_INIT32 :
									sfl_pkg::CRC_INIT16;
							end else begin
								s_nxt.txShift = fillByte;
								s_nxt.txState = sfl_pkg::TX_FILL;
							end
						end
						sfl_pkg::TX_DATA: begin
							if (s_r.txLastCap) begin
								s_nxt.txShift = ~s_nxt.txCrc[7:0];
								s_nxt.txCrc = {8'h00, ~s_nxt.txCrc[31:8]};
								s_nxt.txFcsLeft = checkWidthSelect ? sfl_pkg::FCS_LEFT32 :
									sfl_pkg::FCS_LEFT16;
								s_nxt.txState = sfl_pkg::TX_FCS;
							end else begin
								s_nxt.txLoad = 1'b1;
							end
						end
						default: begin
							if (s_r.txFcsLeft == 3'h0) begin
								s_nxt.txShift = sfl_pkg::FLAG_BYTE;
								s_nxt.txState = sfl_pkg::TX_FLAG;
							end else begin
								s_nxt.txShift = s_r.txCrc[7:0];
								s_nxt.txCrc = {8'h00, s_r.txCrc[31:8]};
								s_nxt.txFcsLeft = s_r.txFcsLeft - 3'h1;
							end
						end
					endcase
				end
			end
		end

		if (rxStep) begin
			s_nxt.rxStb = 1'b0;
			s_nxt.rxFirst = 1'b0;
			s_nxt.rxEnd = 1'b0;
			s_nxt.rxStat = 1'b0;
			// one line sample per receive step
			bitIn = s_r.rxLineSync[1];
			s_nxt.rxWin = {bitIn, s_r.rxWin[7:1]};
			onesNew = !bitIn ? 4'h0 :
				(s_r.rxOnes == sfl_pkg::ABORT_RUN) ? s_r.rxOnes : s_r.rxOnes + 4'h1;
			s_nxt.rxOnes = onesNew;
			if (s_r.rxStatPend) begin
				s_nxt.rxByte = s_r.rxStatByte;
				s_nxt.rxStb = 1'b1;
				s_nxt.rxStat = 1'b1;
				s_nxt.rxStatPend = 1'b0;
			end
			if (s_nxt.rxWin == sfl_pkg::FLAG_BYTE) begin
				if (s_r.rxState == sfl_pkg::RX_FRAME && s_r.rxHoldValid) begin
					stat[sfl_pkg::ST_FCS_ERR] = checkWidthSelect ?
						(s_r.rxHoldCrc != sfl_pkg::CRC_GOOD32) :
						(s_r.rxHoldCrc[15:0] != sfl_pkg::CRC_GOOD16);
					stat[sfl_pkg::ST_OCTET_ERR] = (s_r.rxBitCnt != 3'h7);
					stat[sfl_pkg::ST_FRAME_ERR] = stat[sfl_pkg::ST_OCTET_ERR] ||
						(s_r.rxCount < (checkWidthSelect ? sfl_pkg::MIN_BYTES32 :
						sfl_pkg::MIN_BYTES16));
					if (lnk.rxRoomFlag) begin
						// last check byte with end marker
						s_nxt.rxByte = s_r.rxHold;
						s_nxt.rxStb = 1'b1;
						s_nxt.rxEnd = 1'b1;
						s_nxt.rxFirst = s_r.rxFirstPend;
					end
					s_nxt.rxStatByte = stat;
					s_nxt.rxStatPend = 1'b1;
				end
				s_nxt.rxState = sfl_pkg::RX_FRAME;
				s_nxt.rxBitCnt = 3'h0;
				s_nxt.rxCount = 3'h0;
				s_nxt.rxHoldValid = 1'b0;
				s_nxt.rxFirstPend = 1'b1;
				s_nxt.rxCrc = checkWidthSelect ? sfl_pkg::CRC_INIT32 : sfl_pkg::CRC_INIT16;
			end else if (s_r.rxState == sfl_pkg::RX_FRAME) begin
				if (onesNew == sfl_pkg::ABORT_RUN) begin
					// idle ones after a closed frame end silently
					if (s_r.rxCount != 3'h0) begin
						stat[sfl_pkg::ST_ABORT] = 1'b1;
						s_nxt.rxStatByte = stat;
						s_nxt.rxStatPend = 1'b1;
					end
					s_nxt.rxState = sfl_pkg::RX_HUNT;
				end else if (!(s_r.rxOnes == sfl_pkg::STUFF_RUN && !bitIn)) begin
					s_nxt.rxShift = {bitIn, s_r.rxShift[7:1]};
					s_nxt.rxCrc = sfl_pkg::crcStep(s_r.rxCrc, bitIn, checkWidthSelect);
					s_nxt.rxBitCnt = s_r.rxBitCnt + 3'h1;
					if (s_r.rxBitCnt == 3'h7) begin
						// one byte held back so the end marker can ride the last one
						if (s_r.rxHoldValid && lnk.rxRoomFlag) begin
							s_nxt.rxByte = s_r.rxHold;
							s_nxt.rxStb = 1'b1;
							s_nxt.rxFirst = s_r.rxFirstPend;
							s_nxt.rxFirstPend = 1'b0;
						end
						s_nxt.rxHold = s_nxt.rxShift;
						s_nxt.rxHoldValid = 1'b1;
						s_nxt.rxHoldCrc = s_nxt.rxCrc;
						s_nxt.rxCount = s_r.rxCount + {2'h0, (s_r.rxCount != 3'h7)};
					end
				end
			end
		end
	end

	// reset acts without waiting for a clock edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign txLine = s_r.txLine;
	assign lnk.txLoad = s_r.txLoad;
	assign lnk.txUnderrun = s_r.txUnderrun;
	assign lnk.rxByte = s_r.rxByte;
	assign lnk.rxStb = s_r.rxStb;
	assign lnk.rxFirst = s_r.rxFirst;
	assign lnk.rxEnd = s_r.rxEnd;
	assign lnk.rxStat = s_r.rxStat;
endmodule
`default_nettype wire

// ### core/sfl_link_if.sv
// byte-side link between the frame controller and its user logic
`timescale 1ns/1ps
`default_nettype none
interface sfl_link_if;
	logic txSerialClock;
	logic txEn;
	logic [7:0] txByte;
	logic txPending;
	logic txLast;
	logic txLoad;
	logic txUnderrun;
	logic rxSerialClock;
	logic rxEn;
	logic rxRoomFlag;
	logic [7:0] rxByte;
	logic rxStb;
	logic rxFirst;
	logic rxEnd;
	logic rxStat;

	modport device (
		input txSerialClock, txEn, txByte, txPending, txLast,
		output txLoad, txUnderrun,
		input rxSerialClock, rxEn, rxRoomFlag,
		output rxByte, rxStb, rxFirst, rxEnd, rxStat
	);

	modport user (
		output txSerialClock, txEn, txByte, txPending, txLast,
		input txLoad, txUnderrun,
		output rxSerialClock, rxEn, rxRoomFlag,
		input rxByte, rxStb, rxFirst, rxEnd, rxStat
	);
endinterface
`default_nettype wire

// ### core/sfl_pkg.sv
// shared constants, types and the check-sequence step for the serial frame link
package sfl_pkg;
	localparam logic [7:0] FLAG_BYTE = 8'h7E;
	localparam logic [7:0] ONES_BYTE = 8'hFF;
	localparam logic [31:0] CRC_INIT16 = 32'h0000FFFF;
	localparam logic [31:0] CRC_INIT32 = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY16 = 32'h00008408;
	localparam logic [31:0] CRC_POLY32 = 32'hEDB88320;
	localparam logic [15:0] CRC_GOOD16 = 16'hF0B8;
	localparam logic [31:0] CRC_GOOD32 = 32'hDEBB20E3;
	localparam logic [3:0] STUFF_RUN = 4'h5;
	localparam logic [3:0] ABORT_RUN = 4'h8;
	localparam logic [2:0] FCS_LEFT16 = 3'h1;
	localparam logic [2:0] FCS_LEFT32 = 3'h3;
	localparam logic [2:0] MIN_BYTES16 = 3'h4;
	localparam logic [2:0] MIN_BYTES32 = 3'h6;
	localparam int ST_FCS_ERR = 0;
	localparam int ST_FRAME_ERR = 1;
	localparam int ST_ABORT = 2;
	localparam int ST_OCTET_ERR = 3;
	localparam int CLK_PERIOD_NS = 8;
	localparam int LINK_PERIOD_NS = 160;
	localparam logic [4:0] LINK_HALF = 5'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RXSTAT = 8'h10;
	localparam int CTRL_TXEN = 0;
	localparam int CTRL_RXEN = 1;
	localparam int TXD_LAST = 8;
	localparam int RXD_VALID = 8;
	localparam int RXD_FIRST = 9;
	localparam int RXD_END = 10;
	localparam int STAT_TXFULL = 0;
	localparam int STAT_RXFULL = 1;
	localparam int STAT_URUN = 2;

	typedef enum logic [1:0] {
		TX_FILL = 2'h0,
		TX_FLAG = 2'h1,
		TX_DATA = 2'h2,
		TX_FCS = 2'h3
	} sfl_tx_state_type;

	typedef enum logic [1:0] {
		RX_HUNT = 2'h0,
		RX_FRAME = 2'h1
	} sfl_rx_state_type;

	// one serial bit into the reflected check register, lsb first
	function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic bitIn,
		input logic wide);
		logic [31:0] poly;
		poly = wide ? CRC_POLY32 : CRC_POLY16;
		crcStep = {1'b0, crc[31:1]} ^ ((crc[0] ^ bitIn) ? poly : 32'h00000000);
	endfunction
endpackage

// ### core/sfl_user.sv
// user end: makes the link clocks, holds one byte each way, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module sfl_user (
	input wire logic mclk,
	input wire logic rst_n,
	sfl_link_if.user lnk,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	typedef struct packed {
		logic [4:0] divCnt;
		logic linkClk;
		logic txEnable;
		logic rxEnable;
		logic [7:0] txBuf;
		logic txBufLast;
		logic txFull;
		logic urunSticky;
		logic [7:0] rxBuf;
		logic rxBufFirst;
		logic rxBufEnd;
		logic rxFull;
		logic [7:0] rxStatBuf;
		logic rxStatValid;
		logic dataWrite;
		logic [7:0] dataAddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic txEn;
		logic [7:0] txByte;
		logic txPending;
		logic txLast;
		logic rxEn;
		logic rxRoom;
	} sfl_user_state_type;

	sfl_user_state_type s_r;
	sfl_user_state_type s_nxt;

	always_comb begin
		logic half;
		logic rise;
		logic [7:0] a;
		half = (s_r.divCnt == sfl_pkg::LINK_HALF - 5'h1);
		rise = half && !s_r.linkClk;
		a = haddr[7:0];
		s_nxt = s_r;
		s_nxt.hreadyout = 1'b1;
		s_nxt.dataWrite = 1'b0;
		s_nxt.divCnt = half ? 5'h00 : s_r.divCnt + 5'h01;
		if (half) begin
			s_nxt.linkClk = !s_r.linkClk;
		end
		if (rise && lnk.txLoad) begin
			s_nxt.txFull = 1'b0;
		end
		if (hsel && htrans[1] && hready) begin
			s_nxt.dataWrite = hwrite;
			s_nxt.dataAddr = a;
			s_nxt.hrdata = 32'h00000000;
			if (!hwrite) begin
				if (a == sfl_pkg::REG_CTRL) begin
					s_nxt.hrdata[sfl_pkg::CTRL_TXEN] = s_r.txEnable;
					s_nxt.hrdata[sfl_pkg::CTRL_RXEN] = s_r.rxEnable;
				end else if (a == sfl_pkg::REG_RXDATA) begin
					s_nxt.hrdata[7:0] = s_r.rxBuf;
					s_nxt.hrdata[sfl_pkg::RXD_VALID] = s_r.rxFull;
					s_nxt.hrdata[sfl_pkg::RXD_FIRST] = s_r.rxBufFirst;
					s_nxt.hrdata[sfl_pkg::RXD_END] = s_r.rxBufEnd;
					s_nxt.rxFull = 1'b0;
				end else if (a == sfl_pkg::REG_STATUS) begin
					s_nxt.hrdata[sfl_pkg::STAT_TXFULL] = s_r.txFull;
					s_nxt.hrdata[sfl_pkg::STAT_RXFULL] = s_r.rxFull;
					s_nxt.hrdata[sfl_pkg::STAT_URUN] = s_r.urunSticky;
				end else if (a == sfl_pkg::REG_RXSTAT) begin
					s_nxt.hrdata[7:0] = s_r.rxStatBuf;
					s_nxt.hrdata[sfl_pkg::RXD_VALID] = s_r.rxStatValid;
					s_nxt.rxStatValid = 1'b0;
				end
			end
		end
		if (s_r.dataWrite) begin
			if (s_r.dataAddr == sfl_pkg::REG_CTRL) begin
				s_nxt.txEnable = hwdata[sfl_pkg::CTRL_TXEN];
				s_nxt.rxEnable = hwdata[sfl_pkg::CTRL_RXEN];
			end else if (s_r.dataAddr == sfl_pkg::REG_TXDATA) begin
				s_nxt.txBuf = hwdata[7:0];
				s_nxt.txBufLast = hwdata[sfl_pkg::TXD_LAST];
				s_nxt.txFull = 1'b1;
			end else if (s_r.dataAddr == sfl_pkg::REG_STATUS) begin
				if (hwdata[sfl_pkg::STAT_URUN]) begin
					s_nxt.urunSticky = 1'b0;
				end
			end
		end
		// events sampled at our own rise; a set beats a clear in the same cycle
		if (rise) begin
			if (lnk.txUnderrun) begin
				s_nxt.urunSticky = 1'b1;
			end
			if (lnk.rxStb && lnk.rxStat) begin
				s_nxt.rxStatBuf = lnk.rxByte;
				s_nxt.rxStatValid = 1'b1;
			end else if (lnk.rxStb) begin
				s_nxt.rxBuf = lnk.rxByte;
				s_nxt.rxBufFirst = lnk.rxFirst;
				s_nxt.rxBufEnd = lnk.rxEnd;
				s_nxt.rxFull = 1'b1;
			end
		end
		// link-facing outputs change mid-period so the far end samples them settled
		if (half && s_r.linkClk) begin
			s_nxt.txEn = s_r.txEnable;
			s_nxt.rxEn = s_r.rxEnable;
			// pending while a byte waits, with its last mark
			s_nxt.txPending = s_nxt.txFull;
			s_nxt.txByte = s_r.txBuf;
			s_nxt.txLast = s_r.txBufLast;
			// room while the receive holder is empty
			s_nxt.rxRoom = !s_nxt.rxFull;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.txSerialClock = s_r.linkClk;
	assign lnk.rxSerialClock = s_r.linkClk;
	assign lnk.txEn = s_r.txEn;
	assign lnk.txByte = s_r.txByte;
	assign lnk.txPending = s_r.txPending;
	assign lnk.txLast = s_r.txLast;
	assign lnk.rxEn = s_r.rxEn;
	assign lnk.rxRoomFlag = s_r.rxRoom;
	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.hreadyout;
	assign hresp = 1'b0;
endmodule
`default_nettype wire

// ### dv/sfl_link_assertions.sv
// link-side checks between the frame controller and its user end
`timescale 1ns/1ps
`default_nettype none
module sfl_link_assertions (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic txSerialClock,
	input wire logic txEn,
	input wire logic txPending,
	input wire logic txLoad,
	input wire logic txUnderrun,
	input wire logic rxSerialClock,
	input wire logic rxEn,
	input wire logic rxStb,
	input wire logic rxFirst,
	input wire logic rxEnd,
	input wire logic rxStat
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// end marker rises and stays high for eight more cycles
	sequence endStep;
		$rose(rxEnd) ##1 rxEnd[*8];
	endsequence
	sequence statStep;
		$fell(rxEnd) && rxStat && rxStb;
	endsequence

	chk_load_width: assert property ($rose(txLoad) |=> txLoad[*8] ##[1:20] !txLoad)
		else $error("byte request width wrong");
	chk_load_on_rise: assert property ($rose(txLoad) |-> txSerialClock)
		else $error("byte request away from link rise");
	chk_load_enabled: assert property ($rose(txLoad) |-> txEn)
		else $error("byte request while disabled");
	chk_urun_cause: assert property ($rose(txUnderrun) |-> $fell(txLoad) && !txPending)
		else $error("underrun without missing byte");
	chk_urun_width: assert property ($rose(txUnderrun) |=> txUnderrun[*8] ##[1:20] !txUnderrun)
		else $error("underrun pulse width wrong");
	chk_mark_strobe: assert property ((rxFirst || rxEnd || rxStat) |-> rxStb)
		else $error("marker without strobe");
	chk_end_then_stat: assert property (endStep |-> ##[1:20] statStep)
		else $error("status not one step after end");
	chk_stb_width: assert property ($rose(rxStb) |=> rxStb[*8] ##[1:40] !rxStb)
		else $error("strobe width wrong");
	chk_stb_on_rise: assert property ($rose(rxStb) |-> rxSerialClock)
		else $error("strobe away from link rise");
	chk_stb_enabled: assert property ($rose(rxStb) |-> rxEn)
		else $error("strobe while disabled");
	chk_first_start: assert property ($rose(rxFirst) |-> $rose(rxStb) && !rxStat)
		else $error("first marker misplaced");
endmodule
`default_nettype wire

// ### dv/tb.sv
// loop-back bench: device serial out feeds its own input, user end driven over the bus
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TIMEOUT_CYCLES = 40000;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic fillSelect = 1'b0;
	logic checkWidthSelect = 1'b0;
	logic txLine;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic dataChk = 1'b0;
	logic [63:0] expQ[$];
	logic [63:0] head;
	logic [31:0] seed = 32'h000013B2;
	logic prevTxClk = 1'b0;
	int runLen = 0;
	int maxRun = 0;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;

	sfl_link_if lnk();
	sfl_device u_sfl_device (.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .fillSelect(fillSelect),
		.checkWidthSelect(checkWidthSelect), .rxLine(txLine), .txLine(txLine));
	sfl_user u_sfl_user (.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	sfl_link_assertions u_sfl_link_assertions (.mclk(mclk), .rst_n(rst_n),
		.txSerialClock(lnk.txSerialClock), .txEn(lnk.txEn), .txPending(lnk.txPending),
		.txLoad(lnk.txLoad), .txUnderrun(lnk.txUnderrun), .rxSerialClock(lnk.rxSerialClock),
		.rxEn(lnk.rxEn), .rxStb(lnk.rxStb), .rxFirst(lnk.rxFirst), .rxEnd(lnk.rxEnd),
		.rxStat(lnk.rxStat));

	always #4 mclk = ~mclk;

	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// own bitwise division, lsb first, so no shared code with the design
	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b,
		input logic w);
		for (int i = 0; i < 8; i++) begin
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? (w ? sfl_pkg::CRC_POLY32 : sfl_pkg::CRC_POLY16)
				: 32'h00000000);
		end
		return c;
	endfunction

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic chk, input logic [31:0] ev, input logic [31:0] mask, output logic [31:0] rd);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		@(posedge mclk);
		while (!hreadyout) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= wd;
		if (chk) begin
			expQ.push_back({ev & mask, mask});
			dataChk <= 1'b1;
		end
		@(posedge mclk);
		while (!hreadyout) @(posedge mclk);
		dataChk <= 1'b0;
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] junk;
		ahb(1'b1, a, d, 1'b0, 32'h00000000, 32'h00000000, junk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] mask);
		logic [31:0] junk;
		ahb(1'b0, a, 32'h00000000, 1'b1, ev, mask, junk);
	endtask

	// result watcher: oldest note against the read data of each checked transfer
	always @(posedge mclk) begin
		cycles++;
		if (dataChk && hreadyout) begin
			head = expQ.pop_front();
			cmp("read data", head[63:32], hrdata & head[31:0]);
			cmp("response", 32'h00000000, 32'(hresp));
		end
		prevTxClk <= lnk.txSerialClock;
		if (prevTxClk && !lnk.txSerialClock) begin
			runLen = txLine ? runLen + 1 : 0;
			if (runLen > maxRun) maxRun = runLen;
		end
		// a hang counts as a mismatch and still reaches the verdict
		if (cycles == TIMEOUT_CYCLES) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic frame(input int n);
		logic [7:0] d[$];
		logic [31:0] c;
		logic [31:0] s;
		int sent;
		int got;
		c = checkWidthSelect ? sfl_pkg::CRC_INIT32 : sfl_pkg::CRC_INIT16;
		sent = 0;
		got = 0;
		for (int k = 0; k < n; k++) begin
			d.push_back(k == 0 ? 8'hFF : rnd());
			c = crcByte(c, d[k], checkWidthSelect);
		end
		c = ~c;
		for (int k = 0; k < (checkWidthSelect ? 4 : 2); k++) begin
			d.push_back(c[8*k +: 8]);
		end
		while (got < d.size()) begin
			ahb(1'b0, sfl_pkg::REG_STATUS, 32'h00000000, 1'b0, 32'h00000000, 32'h00000000, s);
			if (s[sfl_pkg::STAT_RXFULL]) begin
				rdc(sfl_pkg::REG_RXDATA, {21'h00000, got == d.size() - 1, got == 0, 1'b1,
					d[got]}, 32'h000007FF);
				got++;
			end
			if (!s[sfl_pkg::STAT_TXFULL] && sent < n) begin
				wr(sfl_pkg::REG_TXDATA, {23'h00000, sent == n - 1, d[sent]});
				sent++;
			end
		end
		repeat (200) @(posedge mclk);
		rdc(sfl_pkg::REG_RXSTAT, 32'h00000100, 32'h000001FF);
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		wr(sfl_pkg::REG_CTRL, 32'h00000003);
		for (int cfg = 0; cfg < 4; cfg++) begin
			fillSelect <= cfg[0];
			checkWidthSelect <= cfg[1];
			repeat (200) @(posedge mclk);
			maxRun = 0;
			repeat (400) @(posedge mclk);
			if (cfg[0]) begin
				cmp("idle ones run", 32'h00000001, 32'(maxRun >= 8));
			end else begin
				cmp("idle flag run", 32'h00000006, 32'(maxRun));
			end
			frame(2 + int'(rnd() % 8'h04));
			if (!cfg[0]) begin
				cmp("frame ones run", 32'h00000006, 32'(maxRun));
			end
		end
		fillSelect <= 1'b0;
		wr(sfl_pkg::REG_CTRL, 32'h00000002);
		wr(sfl_pkg::REG_TXDATA, 32'h00000055);
		repeat (800) @(posedge mclk);
		rdc(sfl_pkg::REG_STATUS, 32'h00000001, 32'h00000005);
		wr(sfl_pkg::REG_CTRL, 32'h00000003);
		// the line stood at one while disabled, so the run count restarts
		// once the opening flag is under way, well before the abort begins
		repeat (200) @(posedge mclk);
		maxRun = 0;
		runLen = 0;
		repeat (2800) @(posedge mclk);
		rdc(sfl_pkg::REG_STATUS, 32'h00000004, 32'h00000005);
		cmp("abort ones run", 32'h00000008, 32'(maxRun));
		rdc(sfl_pkg::REG_RXSTAT, 32'h00000104, 32'h00000104);
		wr(sfl_pkg::REG_STATUS, 32'h00000004);
		rdc(sfl_pkg::REG_STATUS, 32'h00000000, 32'h00000004);
		tally_and_finish();
	end
endmodule
`default_nettype wire
